// ---- hw/tmr_timer16.sv ----
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
// Functional notes
// - Filtered capture input changes only after four equal new samples.
// - Filter adds four cycles of latency before the capture event.
// - Edge select zero means falling edge, one means rising edge.
// - Capture trigger copies counter into capture register and sets capture flag.
// - Capture register used as top disconnects the capture pin.
// - Clock select: stop, undivided, or divide by 8, 64, 256, 1024.
// - Clock select 110 counts falling, 111 rising external pin edges.
// - External pin edges count even when the pin is an output.
// - Force strobes work only in non-PWM modes.
// - Force strobe acts as a compare match on the waveform output.
// - Force strobe sets no flag, no interrupt, never clears the counter.
// - Force bits are write-only and read as zero.
// - Counter is reached through two bytes with a shared high-byte temp.
// - Counter write suppresses the compare match on the next timer tick.
// - Compare registers are compared continuously; match drives flag and output.
// - Compare high byte staged in temp, committed with the low byte.
// - Capture source is the pin or optionally the analog comparator.
// - Capture reads return both bytes of one instant via temp.
// - Capture interrupt needs enable, global flag and capture flag.
// - Compare interrupts need channel enable, global flag and compare flag.
// - Overflow interrupt needs enable, global flag and overflow flag.
// - Upper mode bits join lower mode bits into the four-bit mode.
// - Compare flag sets on the tick after counter equals compare value.
// - Flags clear on vector execution or on writing one.
module tmr_timer16
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins and neighbours
    input wire logic capture_pin_i,
    input wire logic ext_count_pin_i,
    input wire logic comparator_i,
    input wire logic capture_from_comparator_i,
    input wire logic global_irq_enable_i,
    input wire logic [3:0] vector_done_i,
    // Waveform and interrupt outputs
    output logic wave_out_a_o,
    output logic wave_out_a_oe_o,
    output logic wave_out_b_o,
    output logic wave_out_b_oe_o,
    output logic irq_capture_o,
    output logic irq_compare_a_o,
    output logic irq_compare_b_o,
    output logic irq_overflow_o
);

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] irq_mask;
        logic [7:0] flags;
        logic [7:0] temp;
        logic [15:0] count;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] capt;
        logic count_down;
        logic block_match;
        logic [9:0] presc;
        logic [1:0] capt_sync;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [2:0] capt_hist;
        logic capt_filt;
        logic capt_prev;
        logic wave_a;
        logic wave_b;
        logic oe_a;
        logic oe_b;
        logic [3:0] irq;
        logic ack;
        logic [31:0] rdata;
    } tmr_state_type;

    tmr_state_type s_q;
    tmr_state_type s_d;

    // Output level after a compare match for one channel.
    function automatic logic match_level(input logic [1:0] com, input logic cur,
                                         input logic phase, input logic fast,
                                         input logic up, input logic chan_a,
                                         input logic wm3);
        logic lvl;
        lvl = cur;
        if (!phase && !fast) begin
            case (com)
                2'h1: lvl = ~cur;
                2'h2: lvl = 1'b0;
                2'h3: lvl = 1'b1;
                default: lvl = cur;
            endcase
        end else begin
            case (com)
                2'h1: lvl = (chan_a && wm3) ? ~cur : cur;
                2'h2: lvl = phase ? ~up : 1'b0;
                2'h3: lvl = phase ? up : 1'b1;
                default: lvl = cur;
            endcase
        end
        return lvl;
    endfunction

    logic [3:0] wmode;
    logic phase_m;
    logic fast_m;
    logic capt_top;
    logic [15:0] top;
    logic tick;
    logic [7:0] idx;
    logic req;
    logic wr;
    logic rd;
    logic [7:0] wb;
    logic capt_src;
    logic capt_edge;
    logic match_a;
    logic match_b;
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic [7:0] rd8;
    logic ext_edge;

    always_comb begin
        s_d = s_q;
        wmode = {s_q.ctrl_b[4:3], s_q.ctrl_a[1:0]};
        phase_m = (wmode inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
        fast_m = (wmode inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15});
        capt_top = (wmode inside {4'd8, 4'd10, 4'd12, 4'd14});
        case (wmode)
            4'd1, 4'd5: top = TOP_8BIT;
            4'd2, 4'd6: top = TOP_9BIT;
            4'd3, 4'd7: top = TOP_10BIT;
            4'd4, 4'd9, 4'd11, 4'd15: top = s_q.cmp_a;
            4'd8, 4'd10, 4'd12, 4'd14: top = s_q.capt;
            default: top = TOP_MAX;
        endcase

        // Prescaler runs free; taps pick the counting rate.
        s_d.presc = s_q.presc + 10'h001;
        // External edges from the synchronised pin.
        s_d.ext_sync = {s_q.ext_sync[0], ext_count_pin_i};
        s_d.ext_prev = s_q.ext_sync[1];
        ext_edge = 1'b0;
        case (s_q.ctrl_b[2:0])
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (s_q.presc[2:0] == 3'h7);
            CS_DIV64: tick = (s_q.presc[5:0] == 6'h3f);
            CS_DIV256: tick = (s_q.presc[7:0] == 8'hff);
            CS_DIV1024: tick = (s_q.presc == 10'h3ff);
            // Pin level is read regardless of its direction.
            CS_EXT_FALL: begin
                ext_edge = s_q.ext_prev & ~s_q.ext_sync[1];
                tick = ext_edge;
            end
            CS_EXT_RISE: begin
                ext_edge = ~s_q.ext_prev & s_q.ext_sync[1];
                tick = ext_edge;
            end
            default: tick = 1'b0;
        endcase

        // Noise filter on four successive samples.
        s_d.capt_sync = {s_q.capt_sync[0], capture_pin_i};
        // The newest sample joins the three held ones, so the filter adds four cycles.
        s_d.capt_hist = {s_q.capt_hist[1:0], s_q.capt_sync[1]};
        if ({s_q.capt_hist, s_q.capt_sync[1]} == {FILTER_SAMPLES{~s_q.capt_filt}}) begin
            s_d.capt_filt = ~s_q.capt_filt;
        end
        if (capture_from_comparator_i) begin
            capt_src = comparator_i;
        end else if (s_q.ctrl_b[CTRLB_FILTER]) begin
            // Filtered path adds the filter delay.
            capt_src = s_q.capt_filt;
        end else begin
            capt_src = s_q.capt_sync[1];
        end
        s_d.capt_prev = capt_src;
        capt_edge = s_q.ctrl_b[CTRLB_EDGE] ? (capt_src & ~s_q.capt_prev)
                                           : (~capt_src & s_q.capt_prev);

        set_f = 8'h00;
        clr_f = 8'h00;
        // Capture loads counter and sets flag.
        if (capt_edge && !capt_top) begin
            s_d.capt = s_q.count;
            set_f[FLAG_CAPT] = 1'b1;
        end
        // Capture top blocks pin captures; flag marks top instead.
        if (capt_top && tick && s_q.count == top) begin
            set_f[FLAG_CAPT] = 1'b1;
        end

        // A counter write blocks the next tick's match.
        match_a = tick && !s_q.block_match && (s_q.count == s_q.cmp_a);
        match_b = tick && !s_q.block_match && (s_q.count == s_q.cmp_b);
        // Flags set on the tick leaving the equal value.
        set_f[FLAG_CMPA] = match_a;
        set_f[FLAG_CMPB] = match_b;
        if (tick) begin
            s_d.block_match = 1'b0;
        end
        if (match_a) begin
            s_d.wave_a = match_level(s_q.ctrl_a[7:6], s_q.wave_a, phase_m, fast_m,
                                     ~s_q.count_down, 1'b1, wmode[3]);
        end
        if (match_b) begin
            s_d.wave_b = match_level(s_q.ctrl_a[5:4], s_q.wave_b, phase_m, fast_m,
                                     ~s_q.count_down, 1'b0, wmode[3]);
        end

        if (tick) begin
            if (phase_m) begin
                if (!s_q.count_down && s_q.count >= top) begin
                    s_d.count_down = 1'b1;
                    s_d.count = s_q.count - 16'h0001;
                end else if (s_q.count_down && s_q.count == 16'h0000) begin
                    s_d.count_down = 1'b0;
                    s_d.count = 16'h0001;
                    set_f[FLAG_OVF] = 1'b1;
                end else begin
                    s_d.count = s_q.count_down ? s_q.count - 16'h0001
                                               : s_q.count + 16'h0001;
                end
            end else begin
                s_d.count_down = 1'b0;
                if (s_q.count == top) begin
                    s_d.count = 16'h0000;
                    if (fast_m) begin
                        set_f[FLAG_OVF] = 1'b1;
                        if (s_q.ctrl_a[7]) s_d.wave_a = ~s_q.ctrl_a[6];
                        if (s_q.ctrl_a[5]) s_d.wave_b = ~s_q.ctrl_a[4];
                    end
                end else begin
                    s_d.count = s_q.count + 16'h0001;
                end
                if (!fast_m && s_q.count == TOP_MAX) begin
                    set_f[FLAG_OVF] = 1'b1;
                end
            end
        end

        // Wishbone decode; only byte lane 0 carries data.
        // The registered ack masks the request, so a held strobe is answered every other cycle.
        req = wb_cyc_i && wb_stb_i && !s_q.ack;
        wr = req && wb_we_i && wb_sel_i[0];
        rd = req && !wb_we_i;
        idx = wb_adr_i[9:2];
        wb = wb_dat_i[7:0];
        s_d.ack = req;
        rd8 = 8'h00;
        case (idx)
            IDX_FLAGS: rd8 = s_q.flags;
            IDX_IRQ_MASK: rd8 = s_q.irq_mask;
            IDX_FORCE: rd8 = 8'h00;
            IDX_CTRL_A: rd8 = s_q.ctrl_a;
            IDX_CTRL_B: rd8 = s_q.ctrl_b;
            IDX_COUNT_L: rd8 = s_q.count[7:0];
            IDX_CMPA_L: rd8 = s_q.cmp_a[7:0];
            IDX_CMPB_L: rd8 = s_q.cmp_b[7:0];
            IDX_CAPT_L: rd8 = s_q.capt[7:0];
            IDX_COUNT_H, IDX_CAPT_H: rd8 = s_q.temp;
            IDX_CMPA_H: rd8 = s_q.cmp_a[15:8];
            IDX_CMPB_H: rd8 = s_q.cmp_b[15:8];
            default: rd8 = 8'h00;
        endcase
        s_d.rdata = rd ? {24'h000000, rd8} : 32'h00000000;
        // Low-byte read latches the high byte of the same instant.
        if (rd && idx == IDX_CAPT_L) s_d.temp = s_q.capt[15:8];
        // Counter high byte travels through temp on reads too.
        if (rd && idx == IDX_COUNT_L) s_d.temp = s_q.count[15:8];

        if (wr) begin
            case (idx)
                IDX_FLAGS: clr_f = wb & FLAGS_MASK;
                IDX_IRQ_MASK: s_d.irq_mask = wb & FLAGS_MASK;
                IDX_CTRL_A: s_d.ctrl_a = wb & CTRLA_WMASK;
                IDX_CTRL_B: s_d.ctrl_b = wb & CTRLB_WMASK;
                IDX_FORCE: begin
                    // Forced match drives the waveform output.
                    // No flag is set and the counter is untouched.
                    if (!phase_m && !fast_m && wb[FORCE_A]) begin
                        s_d.wave_a = match_level(s_q.ctrl_a[7:6], s_q.wave_a, 1'b0,
                                                 1'b0, 1'b1, 1'b1, 1'b0);
                    end
                    if (!phase_m && !fast_m && wb[FORCE_B]) begin
                        s_d.wave_b = match_level(s_q.ctrl_a[5:4], s_q.wave_b, 1'b0,
                                                 1'b0, 1'b1, 1'b0, 1'b0);
                    end
                end
                IDX_COUNT_H, IDX_CMPA_H, IDX_CMPB_H, IDX_CAPT_H: s_d.temp = wb;
                IDX_COUNT_L: begin
                    s_d.count = {s_q.temp, wb};
                    s_d.block_match = 1'b1;
                end
                IDX_CMPA_L: s_d.cmp_a = {s_q.temp, wb};
                IDX_CMPB_L: s_d.cmp_b = {s_q.temp, wb};
                IDX_CAPT_L: s_d.capt = {s_q.temp, wb};
                default: s_d.block_match = s_q.block_match;
            endcase
        end

        // Clear by vector or by writing one; a set in the same cycle wins.
        clr_f[FLAG_CAPT] = clr_f[FLAG_CAPT] | vector_done_i[3];
        clr_f[FLAG_CMPB] = clr_f[FLAG_CMPB] | vector_done_i[2];
        clr_f[FLAG_CMPA] = clr_f[FLAG_CMPA] | vector_done_i[1];
        clr_f[FLAG_OVF] = clr_f[FLAG_OVF] | vector_done_i[0];
        s_d.flags = ((s_q.flags & ~clr_f) | set_f) & FLAGS_MASK;

        // Output enables are registered so the pins come straight from flops.
        s_d.oe_a = s_d.ctrl_a[7] | s_d.ctrl_a[6];
        s_d.oe_b = s_d.ctrl_a[5] | s_d.ctrl_a[4];
        // Requests use the next flag value so they rise together with the flag.

        s_d.irq[3] = s_d.flags[FLAG_CAPT] & s_q.irq_mask[FLAG_CAPT] & global_irq_enable_i;
        s_d.irq[2] = s_d.flags[FLAG_CMPB] & s_q.irq_mask[FLAG_CMPB] & global_irq_enable_i;
        s_d.irq[1] = s_d.flags[FLAG_CMPA] & s_q.irq_mask[FLAG_CMPA] & global_irq_enable_i;
        s_d.irq[0] = s_d.flags[FLAG_OVF] & s_q.irq_mask[FLAG_OVF] & global_irq_enable_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.ctrl_a <= REG8_RESET;
            s_q.ctrl_b <= REG8_RESET;
            s_q.irq_mask <= REG8_RESET;
            s_q.flags <= REG8_RESET;
            s_q.count <= REG16_RESET;
            s_q.cmp_a <= REG16_RESET;
            s_q.cmp_b <= REG16_RESET;
            s_q.capt <= REG16_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;
    assign wave_out_a_o = s_q.wave_a;
    assign wave_out_b_o = s_q.wave_b;
    assign wave_out_a_oe_o = s_q.oe_a;
    assign wave_out_b_oe_o = s_q.oe_b;
    assign irq_capture_o = s_q.irq[3];
    assign irq_compare_b_o = s_q.irq[2];
    assign irq_compare_a_o = s_q.irq[1];
    assign irq_overflow_o = s_q.irq[0];

endmodule // tmr_timer16

// ---- hw/tmr_pkg.sv ----
package tmr_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_FLAGS = 8'h0b;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h0c;
    localparam logic [7:0] IDX_FORCE = 8'h22;
    localparam logic [7:0] IDX_CAPT_L = 8'h24;
    localparam logic [7:0] IDX_CAPT_H = 8'h25;
    localparam logic [7:0] IDX_CMPA_L = 8'h26;
    localparam logic [7:0] IDX_CMPA_H = 8'h27;
    localparam logic [7:0] IDX_CMPB_L = 8'h28;
    localparam logic [7:0] IDX_CMPB_H = 8'h29;
    localparam logic [7:0] IDX_COUNT_L = 8'h2c;
    localparam logic [7:0] IDX_COUNT_H = 8'h2d;
    localparam logic [7:0] IDX_CTRL_B = 8'h2e;
    localparam logic [7:0] IDX_CTRL_A = 8'h2f;
    // Field positions.
    localparam int CTRLB_FILTER = 7;
    localparam int CTRLB_EDGE = 6;
    localparam int FORCE_A = 7;
    localparam int FORCE_B = 6;
    localparam int FLAG_CAPT = 5;
    localparam int FLAG_CMPB = 2;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_OVF = 0;
    // Writable bit masks and reset values.
    localparam logic [7:0] CTRLA_WMASK = 8'hf3;
    localparam logic [7:0] CTRLB_WMASK = 8'hdf;
    localparam logic [7:0] FLAGS_MASK = 8'h27;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    // Clock sources.
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int FILTER_SAMPLES = 4;
    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
endpackage

// ---- test/tmr_timer16_chk.sv ----
`timescale 1ns/1ns
module tmr_timer16_chk
    import tmr_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Interrupt side
    input wire logic global_irq_enable_i,
    input wire logic irq_capture_o,
    input wire logic irq_compare_a_o,
    input wire logic irq_compare_b_o,
    input wire logic irq_overflow_o
);
    logic rd_force;
    assign rd_force = wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i[9:2] == IDX_FORCE;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack did not follow request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_dat_upper;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("upper read data not zero");
    property p_force_zero;
        rd_force && wb_ack_o |-> wb_dat_o[7:0] == 8'h00;
    endproperty
    a_force_zero: assert property (p_force_zero) else $error("force reads nonzero");
    property p_irq_capt;
        $rose(irq_capture_o) |-> $past(global_irq_enable_i);
    endproperty
    a_irq_capt: assert property (p_irq_capt) else $error("capture irq ungated");
    property p_irq_cmpa;
        !$past(global_irq_enable_i) |-> !irq_compare_a_o;
    endproperty
    a_irq_cmpa: assert property (p_irq_cmpa) else $error("compare a irq ungated");
    property p_irq_cmpb;
        !global_irq_enable_i ##1 !global_irq_enable_i |-> !irq_compare_b_o;
    endproperty
    a_irq_cmpb: assert property (p_irq_cmpb) else $error("compare b irq ungated");
    property p_irq_ovf;
        irq_overflow_o |-> $past(global_irq_enable_i);
    endproperty
    a_irq_ovf: assert property (p_irq_ovf) else $error("overflow irq ungated");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_capt: cover property ($rose(irq_capture_o));
    c_ovf: cover property ($rose(irq_overflow_o));
endmodule // tmr_timer16_chk
bind tmr_timer16 tmr_timer16_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .global_irq_enable_i(global_irq_enable_i),
    .irq_capture_o(irq_capture_o), .irq_compare_a_o(irq_compare_a_o),
    .irq_compare_b_o(irq_compare_b_o), .irq_overflow_o(irq_overflow_o));

// ---- test/tmr_timer16_bench.sv ----
`timescale 1ns/1ns
module tmr_timer16_bench
    import tmr_pkg::*;
;
    typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} tmr_row_type;
    tmr_row_type rows [6] = '{'{IDX_CTRL_B, 8'hdf, 8'hdf}, '{IDX_CTRL_A, 8'hff, 8'hf3},
        '{IDX_IRQ_MASK, 8'hff, 8'h27}, '{IDX_FORCE, 8'hc0, 8'h00},
        '{IDX_FLAGS, 8'hff, 8'h00}, '{8'h3f, 8'hff, 8'h00}};
    int dv [5] = '{1, 8, 64, 256, 1024};
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0, vector_done_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, wave_out_a_o, wave_out_a_oe_o, wave_out_b_o, wave_out_b_oe_o;
    logic irq_capture_o, irq_compare_a_o, irq_compare_b_o, irq_overflow_o;
    logic capture_pin_i = 1'b0, ext_count_pin_i = 1'b0, comparator_i = 1'b0;
    logic capture_from_comparator_i = 1'b0, global_irq_enable_i = 1'b0;
    int miscompares = 0, n_compared = 0;
    logic [7:0] rv;
    logic [15:0] v16;
    always #20 clk_i = ~clk_i;
    tmr_timer16 dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capture_pin_i(capture_pin_i),
        .ext_count_pin_i(ext_count_pin_i), .comparator_i(comparator_i),
        .capture_from_comparator_i(capture_from_comparator_i),
        .global_irq_enable_i(global_irq_enable_i), .vector_done_i(vector_done_i),
        .wave_out_a_o(wave_out_a_o), .wave_out_a_oe_o(wave_out_a_oe_o),
        .wave_out_b_o(wave_out_b_o), .wave_out_b_oe_o(wave_out_b_oe_o),
        .irq_capture_o(irq_capture_o), .irq_compare_a_o(irq_compare_a_o),
        .irq_compare_b_o(irq_compare_b_o), .irq_overflow_o(irq_overflow_o));
    task automatic results();
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        n_compared++;
        if (got !== ex) begin
            $display("Error %s expected %h seen %h", nm, ex, got);
            miscompares++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One classic cycle; entered and left in the time step of a rising edge.
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rv = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            results();
        end
        @(posedge clk_i);
    endtask
    task automatic w16(input logic [7:0] hi, input logic [15:0] v);
        bus(1'b1, hi, v[15:8]);
        bus(1'b1, hi - 8'h01, v[7:0]);
    endtask
    task automatic r16(input logic [7:0] lo);
        bus(1'b0, lo, 8'h00);
        v16[7:0] = rv;
        bus(1'b0, lo + 8'h01, 8'h00);
        v16[15:8] = rv;
    endtask
    initial begin
        tick(5);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            bus(1'b0, rows[i].idx, 8'h00);
            chk("reset value", REG8_RESET, rv);
            bus(1'b1, rows[i].idx, rows[i].wd);
            bus(1'b0, rows[i].idx, 8'h00);
            chk("read back", rows[i].ex, rv);
        end
        bus(1'b1, IDX_CTRL_A, 8'h00);
        bus(1'b1, IDX_CTRL_B, 8'h00);
        w16(IDX_CMPA_H, 16'h1234);
        bus(1'b1, IDX_CMPA_H, 8'hab);
        bus(1'b0, IDX_CMPA_H, 8'h00);
        chk("staged high", 16'h0012, rv);
        bus(1'b1, IDX_CMPA_L, 8'hcd);
        r16(IDX_CMPA_L);
        chk("compare a", 16'habcd, v16);
        w16(IDX_COUNT_H, 16'h0345);
        r16(IDX_COUNT_L);
        chk("count", 16'h0345, v16);
        for (int i = 0; i < 5; i++) begin
            w16(IDX_COUNT_H, 16'h0000);
            bus(1'b1, IDX_CTRL_B, {5'h00, 3'(i + 1)});
            tick(dv[i] * 8);
            bus(1'b1, IDX_CTRL_B, {5'h00, CS_STOP});
            r16(IDX_COUNT_L);
            chk("prescaled count", 16'h0001, 16'(v16 >= 7 && v16 <= 12));
        end
        for (int m = 0; m < 2; m++) begin
            w16(IDX_COUNT_H, 16'h0000);
            bus(1'b1, IDX_CTRL_B, {5'h00, 3'(CS_EXT_FALL + m)});
            repeat (5) begin
                ext_count_pin_i <= 1'b1;
                tick(4);
                ext_count_pin_i <= 1'b0;
                tick(4);
            end
            tick(8);
            bus(1'b1, IDX_CTRL_B, {5'h00, CS_STOP});
            r16(IDX_COUNT_L);
            chk("external count", 16'h0005, v16);
        end
        bus(1'b1, IDX_IRQ_MASK, 8'h20);
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, IDX_CTRL_B, 8'(e << CTRLB_EDGE));
            capture_pin_i <= !e;
            tick(10);
            bus(1'b1, IDX_FLAGS, 8'h20);
            w16(IDX_COUNT_H, 16'h0100 + 16'(e));
            global_irq_enable_i <= 1'(e);
            capture_pin_i <= 1'(e);
            tick(10);
            r16(IDX_CAPT_L);
            chk("capture", 16'h0100 + 16'(e), v16);
            chk("capture irq", 16'(e), 16'(irq_capture_o));
            vector_done_i <= 4'h8;
            @(posedge clk_i);
            vector_done_i <= 4'h0;
            capture_pin_i <= !e;
            tick(10);
            bus(1'b0, IDX_FLAGS, 8'h00);
            chk("wrong edge flag", 16'h0000, 16'(rv & 8'h20));
        end
        bus(1'b1, IDX_CTRL_B, 8'hc0);
        capture_pin_i <= 1'b1;
        tick(3);
        capture_pin_i <= 1'b0;
        tick(12);
        bus(1'b0, IDX_FLAGS, 8'h00);
        chk("glitch flag", 16'h0000, 16'(rv & 8'h20));
        capture_pin_i <= 1'b1;
        tick(3);
        bus(1'b0, IDX_FLAGS, 8'h00);
        chk("early flag", 16'h0000, 16'(rv & 8'h20));
        tick(10);
        bus(1'b0, IDX_FLAGS, 8'h00);
        chk("filtered flag", 16'h0020, 16'(rv & 8'h20));
        bus(1'b1, IDX_FLAGS, 8'hff);
        bus(1'b1, IDX_IRQ_MASK, 8'h07);
        global_irq_enable_i <= 1'b1;
        w16(IDX_CMPB_H, 16'h0008);
        w16(IDX_CMPA_H, 16'h0005);
        w16(IDX_COUNT_H, 16'hfff8);
        bus(1'b1, IDX_CTRL_B, {5'h00, CS_DIV1});
        tick(30);
        bus(1'b1, IDX_CTRL_B, {5'h00, CS_STOP});
        bus(1'b0, IDX_FLAGS, 8'h00);
        chk("match flags", 16'h0007, 16'(rv));
        chk("irqs", 16'h0007, {13'h0, irq_compare_b_o, irq_compare_a_o, irq_overflow_o});
        global_irq_enable_i <= 1'b0;
        tick(3);
        chk("gated irqs", 16'h0000, {13'h0, irq_compare_b_o, irq_compare_a_o, irq_overflow_o});
        bus(1'b1, IDX_FLAGS, 8'hff);
        bus(1'b1, IDX_CTRL_B, {5'h00, CS_DIV1});
        w16(IDX_COUNT_H, 16'h0005);
        bus(1'b1, IDX_CTRL_B, {5'h00, CS_STOP});
        bus(1'b0, IDX_FLAGS, 8'h00);
        chk("blocked match", 16'h0000, 16'(rv & 8'h02));
        bus(1'b1, IDX_CTRL_A, 8'h70);
        bus(1'b1, IDX_FORCE, 8'hc0);
        tick(2);
        chk("forced outputs", 16'h000f, {12'h0, wave_out_a_oe_o, wave_out_a_o, wave_out_b_oe_o, wave_out_b_o});
        bus(1'b0, IDX_FLAGS, 8'h00);
        chk("forced flags", 16'h0000, 16'(rv));
        bus(1'b1, IDX_CTRL_A, 8'h71);
        bus(1'b1, IDX_FORCE, 8'h80);
        tick(2);
        chk("pwm force", 16'h0001, 16'(wave_out_a_o));
        bus(1'b1, IDX_CTRL_B, 8'h40);
        w16(IDX_COUNT_H, 16'h0222);
        capture_from_comparator_i <= 1'b1;
        tick(2);
        comparator_i <= 1'b1;
        tick(4);
        r16(IDX_CAPT_L);
        chk("comparator capture", 16'h0222, v16);
        bus(1'b1, IDX_CTRL_A, 8'h00);
        bus(1'b1, IDX_CTRL_B, 8'h58);
        w16(IDX_COUNT_H, 16'h0333);
        comparator_i <= 1'b0;
        tick(2);
        comparator_i <= 1'b1;
        tick(4);
        r16(IDX_CAPT_L);
        chk("capture top", 16'h0222, v16);
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, IDX_CTRL_A, 8'h00);
        chk("second reset", 16'h0000, {8'h00, rv});
        chk("reset outputs", 16'h0000, {12'h0, wave_out_a_oe_o, wave_out_a_o,
            wave_out_b_oe_o, wave_out_b_o});
        results();
    end
endmodule // tmr_timer16_bench
